// ===== rtl/tdms_top.sv
// Time reference ingest, timebase steering, announce fields and master selection.
`timescale 1ns/1ps
// Contract
// - First priority is compared first; the better first priority wins outright. The code first drops any candidate with clock class above 127.
// - Equal first priorities rank on clock class, then accuracy, then variance.
// - Identical clock quality is decided by the second priority.
// - Clock class above 127 marks a clock not required to be grandmaster.
// - Serial port accepts only timing sentences; other sentence types are discarded.
// - Accepted day, hour, minute, second set the coarse phase of the timebase.
// - Serial port failure is detected and its messages ignored while it lasts.
// - Timebase stays aligned through serial failure while the pulse stays good.
// - Traceable mode aligns the timebase to the protocol epoch used for timestamps.
// - Traceable announce: timescale true, leap valid, time and frequency traceable.
// - Traceable announce carries configured UTC offset and time source as valid.
// - Traceable announced class is configured value, else 6 without profile.
// - Seconds rollover is steered onto the pulse rising edge, setting rate and phase.
// - Host configures traceability; serial handling is the same either way.
// - All earlier attributes equal, candidates are ordered by clock identity.
// - Non-traceable announce: flags false but frequency traceable; class default 13.
// - Pulse loss detected; holdover with enough lock history, else free-run.
module tdms_top
    import tdms_pkg::*;
#(
    parameter int PPS_TIMEOUT_CYCLES = PPS_TIMEOUT_CYC,
    parameter int UART_BIT_CYCLES = BIT_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic low_rate_ref_input,
    input wire logic uart_rx,
    input wire tdms_cfg_t cfg,
    input wire tdms_ds_t local_ds,
    input wire tdms_ds_t cand_ds,
    input wire logic cand_valid,
    input wire logic bmc_restart,
    input wire logic ann_start,
    output tdms_ann_t ann_q,
    output tdms_ds_t best_q,
    output logic best_local_q,
    output logic gm_role_q,
    output logic [31:0] tb_sec_q,
    output logic [29:0] tb_ns_q,
    output tdms_tb_state_t tb_state_q,
    output logic pps_lost_q,
    output logic uart_fail_q
);
    localparam logic [25:0] TMO_LAST = 26'(PPS_TIMEOUT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. The first stage of each feeds only its second stage.
    logic pps_meta_q, pps_sync_q, pps_prev_q;
    logic rx_meta_q, rx_sync_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pps_meta_q <= 1'b0;
            pps_sync_q <= 1'b0;
            pps_prev_q <= 1'b0;
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            pps_meta_q <= low_rate_ref_input;
            pps_sync_q <= pps_meta_q;
            pps_prev_q <= pps_sync_q;
            rx_meta_q <= uart_rx;
            rx_sync_q <= rx_meta_q;
        end
    end

    // Top of second is the rising edge of the reference pulse.
    wire pps_rise = pps_sync_q & ~pps_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Time message reception.
    logic tod_valid;
    tdms_tod_t tod;

    tdms_tod_rx #(
        .BIT_CYCLES(UART_BIT_CYCLES)
    ) u_tod_rx (
        .clk(clk),
        .resetn(resetn),
        .rx(rx_sync_q),
        .tod_valid_q(tod_valid),
        .tod_q(tod)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial port health and pending coarse time.
    logic seen_q, have_edge_q, pend_v_q;
    logic [31:0] pend_sec_q;

    // Messages keep being watched during a failure so the port can recover,
    // but none of them may move the timebase until a clean interval is seen.
    wire tod_take = tod_valid & ~uart_fail_q;
    wire [31:0] utc_add = cfg.traceable ? {16'h0000, cfg.utc_offset} : 32'h00000000;
    wire [31:0] tod_sec = 32'(tod.day) * SEC_PER_DAY + 32'(tod.hour) * SEC_PER_HOUR
                        + 32'(tod.minute) * SEC_PER_MIN + 32'(tod.second) + utc_add;
    // A sentence landing on the edge cycle is counted for the following interval.
    wire seen_d = tod_valid | (seen_q & ~pps_rise);
    wire fail_d = (pps_rise & have_edge_q) ? ~seen_q : uart_fail_q;
    wire pend_v_d = tod_take | (pend_v_q & ~pps_rise);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seen_q <= 1'b0;
            have_edge_q <= 1'b0;
            uart_fail_q <= 1'b0;
            pend_v_q <= 1'b0;
            pend_sec_q <= 32'h00000000;
        end else begin
            seen_q <= seen_d;
            have_edge_q <= (have_edge_q | pps_rise) & ~pps_lost_q;
            uart_fail_q <= fail_d;
            pend_v_q <= pend_v_d;
            if (tod_take) pend_sec_q <= tod_sec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timebase steering. Small errors are slewed at 1 ns per cycle, large
    // ones or a new coarse time are stepped at the edge.
    logic [9:0] slew_q;
    logic slew_slow_q;

    wire ahead = tb_ns_q < NS_HALF_SEC;
    wire [29:0] err_mag = ahead ? tb_ns_q : NS_PER_SEC - tb_ns_q;
    wire err_small = err_mag <= STEP_LIMIT_NS;
    wire do_step = pps_rise & (pend_v_q | ~err_small);
    wire [4:0] ns_inc = (slew_q == 10'h000) ? NS_INC_NOM :
                        (slew_slow_q ? NS_INC_SLOW : NS_INC_FAST);
    wire [30:0] ns_sum = {1'b0, tb_ns_q} + {26'h0000000, ns_inc};
    wire ns_wrap = ns_sum >= {1'b0, NS_PER_SEC};
    wire [30:0] ns_wrapped = ns_sum - {1'b0, NS_PER_SEC};
    wire [29:0] ns_run = ns_wrap ? ns_wrapped[29:0] : ns_sum[29:0];
    wire [31:0] sec_run = tb_sec_q + {31'h00000000, ns_wrap};
    // With the local rollover still to come, stepping must also count the second.
    wire [31:0] sec_step = pend_v_q ? pend_sec_q :
                           (ahead ? tb_sec_q : tb_sec_q + 32'h00000001);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tb_ns_q <= 30'h00000000;
            tb_sec_q <= 32'h00000000;
            slew_q <= 10'h000;
            slew_slow_q <= 1'b0;
        end else if (do_step) begin
            tb_ns_q <= 30'h00000000;
            tb_sec_q <= sec_step;
            slew_q <= 10'h000;
        end else if (pps_rise) begin
            tb_ns_q <= ns_run;
            tb_sec_q <= sec_run;
            slew_q <= err_mag[9:0];
            slew_slow_q <= ahead;
        end else begin
            // Without edges the timebase runs on the local clock, so serial loss
            // alone never disturbs it.
            tb_ns_q <= ns_run;
            tb_sec_q <= sec_run;
            if (slew_q != 10'h000) slew_q <= slew_q - 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse activity monitor and lock state.
    logic [25:0] act_cnt_q;
    logic [3:0] good_q;

    wire tmo = act_cnt_q == TMO_LAST;
    wire [3:0] good_inc = (good_q == 4'hf) ? good_q : good_q + 4'h1;
    tdms_tb_state_t st_d;

    always_comb begin
        st_d = tb_state_q;
        unique case (tb_state_q)
            TB_FREE: if (pps_rise) st_d = TB_ACQ;
            TB_ACQ: begin
                if (tmo) st_d = TB_FREE;
                else if (pps_rise && err_small && good_inc >= LOCK_MIN_GOOD) st_d = TB_LOCK;
            end
            TB_LOCK: begin
                if (tmo) st_d = TB_HOLD;
                else if (pps_rise && !err_small) st_d = TB_ACQ;
            end
            TB_HOLD: if (pps_rise) st_d = TB_ACQ;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_cnt_q <= 26'h0000000;
            good_q <= 4'h0;
            pps_lost_q <= 1'b0;
            tb_state_q <= TB_FREE;
        end else begin
            tb_state_q <= st_d;
            if (pps_rise) begin
                act_cnt_q <= 26'h0000000;
                good_q <= err_small ? good_inc : 4'h0;
                pps_lost_q <= 1'b0;
            end else if (tmo) begin
                good_q <= 4'h0;
                pps_lost_q <= 1'b1;
            end else begin
                act_cnt_q <= act_cnt_q + 26'h0000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Announce fields, sampled from configuration at each announce start.
    wire [7:0] class_def = cfg.traceable ? CLASS_DEF_TRACE : CLASS_DEF_ARB;
    tdms_ann_t ann_d;

    assign ann_d = '{ptp_timescale: cfg.traceable,
                     leap_valid: cfg.traceable,
                     time_traceable: cfg.traceable,
                     freq_traceable: 1'b1,
                     utc_offset_valid: cfg.traceable,
                     utc_offset: cfg.utc_offset,
                     time_source: cfg.time_source,
                     clk_class: cfg.profile_en ? cfg.clk_class : class_def};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ann_q <= '0;
        end else if (ann_start) begin
            ann_q <= ann_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master selection against the running best.
    logic cand_wins;

    tdms_bmc_cmp u_cmp (
        .a(cand_ds),
        .b(best_q),
        .a_better(cand_wins)
    );

    // A candidate that is not meant to be grandmaster never displaces the best.
    wire cand_gm_ok = cand_ds.clk_class <= CLASS_GM_MAX;
    wire cand_take = cand_valid & cand_gm_ok & cand_wins;
    wire local_back = bmc_restart | (best_local_q & ~cand_take);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            best_q <= '0;
            best_local_q <= 1'b1;
            gm_role_q <= 1'b0;
        end else begin
            if (cand_take && !bmc_restart) begin
                best_q <= cand_ds;
            end else if (local_back) begin
                best_q <= local_ds;
            end
            best_local_q <= local_back;
            gm_role_q <= local_back & (local_ds.clk_class <= CLASS_GM_MAX);
        end
    end
endmodule

// ===== rtl/tdms_pkg.sv
// Shared constants, carriers and state types for the time reference and master select block.
package tdms_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam int PPS_TIMEOUT_MS = 1500;
    localparam int PPS_TIMEOUT_CYC = (CLK_HZ / 1000) * PPS_TIMEOUT_MS;
    localparam logic [29:0] NS_PER_SEC = 30'h3b9aca00;
    localparam logic [29:0] NS_HALF_SEC = 30'h1dcd6500;
    localparam logic [29:0] STEP_LIMIT_NS = 30'h000003e8;
    localparam logic [4:0] NS_INC_NOM = 5'h19;
    localparam logic [4:0] NS_INC_SLOW = 5'h18;
    localparam logic [4:0] NS_INC_FAST = 5'h1a;
    localparam logic [3:0] LOCK_MIN_GOOD = 4'h8;
    localparam logic [31:0] SEC_PER_DAY = 32'h00015180;
    localparam logic [31:0] SEC_PER_HOUR = 32'h00000e10;
    localparam logic [31:0] SEC_PER_MIN = 32'h0000003c;

    ////////////////////////////////////////////////////////////////////////////
    // Announce defaults and class limit.
    localparam logic [7:0] CLASS_DEF_TRACE = 8'h06;
    localparam logic [7:0] CLASS_DEF_ARB = 8'h0d;
    localparam logic [7:0] CLASS_GM_MAX = 8'h7f;

    ////////////////////////////////////////////////////////////////////////////
    // Sentence characters.
    localparam logic [7:0] CH_START = 8'h24;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [23:0] TYPE_TIMING = 24'h5a4441;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic [7:0] prio1;
        logic [7:0] clk_class;
        logic [7:0] accuracy;
        logic [15:0] variance;
        logic [7:0] prio2;
        logic [63:0] identity;
    } tdms_ds_t;

    typedef struct packed {
        logic traceable;
        logic profile_en;
        logic [7:0] clk_class;
        logic [15:0] utc_offset;
        logic [7:0] time_source;
    } tdms_cfg_t;

    typedef struct packed {
        logic ptp_timescale;
        logic leap_valid;
        logic time_traceable;
        logic freq_traceable;
        logic utc_offset_valid;
        logic [15:0] utc_offset;
        logic [7:0] time_source;
        logic [7:0] clk_class;
    } tdms_ann_t;

    typedef struct packed {
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } tdms_tod_t;

    typedef enum logic [1:0] {TB_FREE, TB_ACQ, TB_LOCK, TB_HOLD} tdms_tb_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tdms_rx_state_t;

endpackage

// ===== rtl/tdms_bmc_cmp.sv
// Dataset comparison: says whether dataset a beats dataset b.
`timescale 1ns/1ps
module tdms_bmc_cmp
    import tdms_pkg::*;
(
    input wire tdms_ds_t a,
    input wire tdms_ds_t b,
    output logic a_better
);
    // Lower numbers win on every attribute.
    wire p1_diff = a.prio1 != b.prio1;
    wire cls_diff = a.clk_class != b.clk_class;
    wire acc_diff = a.accuracy != b.accuracy;
    wire var_diff = a.variance != b.variance;
    wire p2_diff = a.prio2 != b.prio2;
    wire qual_diff = cls_diff | acc_diff | var_diff;
    wire qual_better = cls_diff ? (a.clk_class < b.clk_class) :
                       acc_diff ? (a.accuracy < b.accuracy) : (a.variance < b.variance);
    wire p2_better = a.prio2 < b.prio2;
    wire id_better = a.identity < b.identity;

    assign a_better = p1_diff ? (a.prio1 < b.prio1) :
                      qual_diff ? qual_better :
                      p2_diff ? p2_better : id_better;
endmodule

// ===== rtl/tdms_tod_rx.sv
// Serial receiver and time sentence parser producing day, hour, minute and second.
`timescale 1ns/1ps
module tdms_tod_rx
    import tdms_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx,
    output logic tod_valid_q,
    output tdms_tod_t tod_q
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

    function automatic logic [7:0] bcd2bin(input logic [3:0] t, input logic [3:0] u);
        bcd2bin = ({4'h0, t} << 3) + ({4'h0, t} << 1) + {4'h0, u};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Byte receiver, sampling at mid bit.
    tdms_rx_state_t rx_st_q;
    logic [15:0] bit_cnt_q;
    logic [2:0] bit_idx_q;
    logic [7:0] shift_q;
    logic byte_stb_q;

    wire bit_end = bit_cnt_q == (rx_st_q == RX_START ? HALF_LAST : BIT_LAST);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_st_q <= RX_IDLE;
            bit_cnt_q <= 16'h0000;
            bit_idx_q <= 3'h0;
            shift_q <= 8'h00;
            byte_stb_q <= 1'b0;
        end else begin
            byte_stb_q <= 1'b0;
            bit_cnt_q <= (bit_end || rx_st_q == RX_IDLE) ? 16'h0000 : bit_cnt_q + 16'h0001;
            unique case (rx_st_q)
                RX_IDLE: if (!rx) rx_st_q <= RX_START;
                RX_START: if (bit_end) rx_st_q <= rx ? RX_IDLE : RX_DATA;
                RX_DATA: if (bit_end) begin
                    shift_q <= {rx, shift_q[7:1]};
                    bit_idx_q <= bit_idx_q + 3'h1;
                    if (bit_idx_q == 3'h7) rx_st_q <= RX_STOP;
                end
                RX_STOP: if (bit_end) begin
                    byte_stb_q <= rx;
                    rx_st_q <= RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sentence parser. Field 0 is the address, 1 is hhmmss, 2 is the day.
    logic in_sent_q;
    logic [3:0] field_q;
    logic [2:0] pos_q;
    logic [23:0] addr_q;
    logic [5:0][3:0] hms_q;
    logic [1:0][3:0] day_q;
    logic hms_ok_q, day_ok_q, bad_q;

    wire is_start = shift_q == CH_START;
    wire is_comma = shift_q == CH_COMMA;
    wire is_end = shift_q == CH_STAR || shift_q == CH_CR || shift_q == CH_LF;
    wire is_digit = shift_q[7:4] == 4'h3 && shift_q[3:0] <= 4'h9;
    wire in_hms = field_q == 4'h1 && pos_q <= 3'h5;
    wire in_day = field_q == 4'h2 && pos_q <= 3'h1;
    // Only timing sentences with complete fields are passed on; others are dropped.
    wire accept = addr_q == TYPE_TIMING && hms_ok_q && day_ok_q && !bad_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_sent_q <= 1'b0;
            field_q <= 4'h0;
            pos_q <= 3'h0;
            addr_q <= 24'h000000;
            hms_q <= '0;
            day_q <= '0;
            hms_ok_q <= 1'b0;
            day_ok_q <= 1'b0;
            bad_q <= 1'b0;
            tod_valid_q <= 1'b0;
            tod_q <= '0;
        end else begin
            tod_valid_q <= 1'b0;
            if (byte_stb_q) begin
                if (is_start) begin
                    in_sent_q <= 1'b1;
                    field_q <= 4'h0;
                    pos_q <= 3'h0;
                    addr_q <= 24'h000000;
                    hms_ok_q <= 1'b0;
                    day_ok_q <= 1'b0;
                    bad_q <= 1'b0;
                end else if (in_sent_q && is_comma) begin
                    if (field_q != 4'hf) field_q <= field_q + 4'h1;
                    pos_q <= 3'h0;
                end else if (in_sent_q && is_end) begin
                    in_sent_q <= 1'b0;
                    tod_valid_q <= accept;
                    tod_q <= '{day: bcd2bin(day_q[0], day_q[1]),
                               hour: bcd2bin(hms_q[0], hms_q[1]),
                               minute: bcd2bin(hms_q[2], hms_q[3]),
                               second: bcd2bin(hms_q[4], hms_q[5])};
                end else if (in_sent_q) begin
                    if (pos_q != 3'h7) pos_q <= pos_q + 3'h1;
                    if (field_q == 4'h0) addr_q <= {addr_q[15:0], shift_q};
                    if ((in_hms || in_day) && !is_digit) bad_q <= 1'b1;
                    if (in_hms) hms_q[pos_q] <= shift_q[3:0];
                    if (in_hms && pos_q == 3'h5) hms_ok_q <= 1'b1;
                    if (in_day) day_q[pos_q[0]] <= shift_q[3:0];
                    if (in_day && pos_q == 3'h1) day_ok_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== test/tdms_src_model.sv
// Behavioural external time source driving the serial time sentences and the pulse.
`timescale 1ns/1ps
module tdms_src_model #(
    parameter int BIT_CYCLES = 16
)
(
    input wire logic clk,
    output logic pps,
    output logic rx
);
    // The serial line rests high between frames, as a receiver output with a pull-up would.
    initial begin
        pps = 1'b0;
        rx = 1'b1;
    end

    task automatic put_bit(input logic b);
        repeat (BIT_CYCLES) @(posedge clk);
        #2 rx = b;
    endtask

    // Whole 8N1 characters, least significant bit first, ending with CR and LF.
    task automatic send(input string s);
        logic [7:0] ch;
        for (int i = 0; i < s.len() + 2; i++) begin
            ch = (i < s.len()) ? s[i] : ((i == s.len()) ? 8'h0d : 8'h0a);
            put_bit(1'b0);
            for (int j = 0; j < 8; j++) begin
                put_bit(ch[j]);
            end
            put_bit(1'b1);
        end
        put_bit(1'b1);
    endtask

    // Rising edge marks the top of the second; callers finish the sentence first.
    task automatic second();
        @(posedge clk);
        #2 pps = 1'b1;
        repeat (40) @(posedge clk);
        #2 pps = 1'b0;
    endtask
endmodule

// ===== test/tdms_top_monitor.sv
// Concurrent checks on the ports of the time reference and master select top.
`timescale 1ns/1ps
module tdms_top_monitor
    import tdms_pkg::*;
#(
    parameter int PPS_TIMEOUT_CYCLES = PPS_TIMEOUT_CYC,
    parameter int UART_BIT_CYCLES = BIT_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic low_rate_ref_input,
    input wire logic uart_rx,
    input wire tdms_cfg_t cfg,
    input wire tdms_ds_t local_ds,
    input wire tdms_ds_t cand_ds,
    input wire logic cand_valid,
    input wire logic bmc_restart,
    input wire logic ann_start,
    input wire tdms_ann_t ann_q,
    input wire tdms_ds_t best_q,
    input wire logic best_local_q,
    input wire logic gm_role_q,
    input wire logic [31:0] tb_sec_q,
    input wire logic [29:0] tb_ns_q,
    input wire tdms_tb_state_t tb_state_q,
    input wire logic pps_lost_q,
    input wire logic uart_fail_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    chk_ann_trace: assert property (ann_start && cfg.traceable |=>
        {ann_q.ptp_timescale, ann_q.leap_valid, ann_q.time_traceable, ann_q.freq_traceable,
        ann_q.utc_offset_valid} == 5'h1f) else $error("traceable announce flags wrong");
    chk_ann_arb: assert property (ann_start && !cfg.traceable |=>
        {ann_q.ptp_timescale, ann_q.leap_valid, ann_q.time_traceable, ann_q.freq_traceable,
        ann_q.utc_offset_valid} == 5'h02) else $error("arbitrary announce flags wrong");
    chk_ann_fields: assert property (ann_start |=>
        ann_q.utc_offset == $past(cfg.utc_offset)
        && ann_q.time_source == $past(cfg.time_source)) else $error("announce fields wrong");
    chk_ann_class: assert property (ann_start |=> ann_q.clk_class ==
        ($past(cfg.profile_en) ? $past(cfg.clk_class) : ($past(cfg.traceable) ?
        CLASS_DEF_TRACE : CLASS_DEF_ARB))) else $error("announce class wrong");
    chk_ann_hold: assert property (!ann_start |=> $stable(ann_q))
        else $error("announce changed without start");
    chk_gm_class: assert property (gm_role_q |-> best_local_q
        && best_q.clk_class <= CLASS_GM_MAX) else $error("grandmaster role wrong");
    chk_cand_skip: assert property (cand_valid && !bmc_restart
        && cand_ds.clk_class > CLASS_GM_MAX |=> best_local_q == $past(best_local_q))
        else $error("high class candidate taken");
    chk_prio1_win: assert property (cand_valid && !bmc_restart &&
        cand_ds.clk_class <= CLASS_GM_MAX && cand_ds.prio1 < best_q.prio1 |=>
        best_q == $past(cand_ds) && !best_local_q) else $error("better priority lost");
    chk_pps_align: assert property ($rose(low_rate_ref_input) |-> ##5
        (tb_ns_q < 30'h000007d0 || tb_ns_q >= 30'h3b9ac618)) else $error("rollover not aligned");
    chk_lost_state: assert property ($rose(pps_lost_q) |-> tb_state_q ==
        ($past(tb_state_q) == TB_LOCK ? TB_HOLD : TB_FREE)) else $error("no holdover on loss");
    cover property (cand_valid ##1 !best_local_q);
    cover property ($rose(uart_fail_q));
    cover property ($rose(pps_lost_q));
endmodule

bind tdms_top tdms_top_monitor #(.PPS_TIMEOUT_CYCLES(PPS_TIMEOUT_CYCLES),
    .UART_BIT_CYCLES(UART_BIT_CYCLES)) mon_u (.clk(clk), .resetn(resetn),
    .low_rate_ref_input(low_rate_ref_input), .uart_rx(uart_rx), .cfg(cfg),
    .local_ds(local_ds), .cand_ds(cand_ds), .cand_valid(cand_valid), .bmc_restart(bmc_restart),
    .ann_start(ann_start), .ann_q(ann_q), .best_q(best_q), .best_local_q(best_local_q),
    .gm_role_q(gm_role_q), .tb_sec_q(tb_sec_q), .tb_ns_q(tb_ns_q), .tb_state_q(tb_state_q),
    .pps_lost_q(pps_lost_q), .uart_fail_q(uart_fail_q));

// ===== test/tdms_top_bench.sv
// Self-checking bench for the time reference and master select top.
`timescale 1ns/1ps
module tdms_top_bench;
    import tdms_pkg::*;
    localparam int TO_CYC = 6000;
    localparam string ZA = "$GPZDA,010203.00,05,01,1970,00,00*";
    logic clk, resetn, pps, rx, cand_valid, bmc_restart, ann_start;
    logic best_local_q, gm_role_q, pps_lost_q, uart_fail_q;
    tdms_cfg_t cfg;
    tdms_ds_t local_ds, cand_ds, best_q;
    tdms_ann_t ann_q;
    logic [31:0] tb_sec_q;
    logic [29:0] tb_ns_q;
    tdms_tb_state_t tb_state_q;
    int errors, check_count;

    tdms_top #(.PPS_TIMEOUT_CYCLES(TO_CYC), .UART_BIT_CYCLES(8)) dut_u (.clk(clk),
        .resetn(resetn), .low_rate_ref_input(pps), .uart_rx(rx), .cfg(cfg), .local_ds(local_ds),
        .cand_ds(cand_ds), .cand_valid(cand_valid), .bmc_restart(bmc_restart),
        .ann_start(ann_start), .ann_q(ann_q), .best_q(best_q), .best_local_q(best_local_q),
        .gm_role_q(gm_role_q), .tb_sec_q(tb_sec_q), .tb_ns_q(tb_ns_q), .tb_state_q(tb_state_q),
        .pps_lost_q(pps_lost_q), .uart_fail_q(uart_fail_q));
    tdms_src_model #(.BIT_CYCLES(8)) src_u (.clk(clk), .pps(pps), .rx(rx));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [111:0] seen, input logic [111:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // One candidate, then a restart back to the local clock.
    task automatic cand(input logic [7:0] p1, input logic [7:0] cl, input logic [7:0] ac,
        input logic [15:0] va, input logic [7:0] p2, input logic [63:0] id, input logic loc);
        tdms_ds_t c;
        c = '{p1, cl, ac, va, p2, id};
        cand_ds = c;
        cand_valid = 1'b1;
        tick(1);
        cand_valid = 1'b0;
        tick(1);
        chk(best_local_q, loc);
        chk(best_q, loc ? local_ds : c);
        chk(gm_role_q, loc);
        bmc_restart = 1'b1;
        tick(1);
        bmc_restart = 1'b0;
        tick(1);
    endtask

    task automatic sec_step(input string s);
        src_u.send(s);
        src_u.second();
        tick(6);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        cand_valid = 1'b0;
        bmc_restart = 1'b0;
        ann_start = 1'b0;
        cand_ds = '0;
        cfg = '{1'b0, 1'b0, 8'h07, 16'h0025, 8'h20};
        local_ds = '{8'h80, 8'h06, 8'h21, 16'h4e5d, 8'h80, 64'h1};
        errors = 0;
        check_count = 0;
        tick(8);
        resetn = 1'b1;
        tick(3);
        chk(gm_role_q, 1'b1);
        cand(8'h7f, 8'h80, 8'h21, 16'h4e5d, 8'h80, 64'h1, 1'b1);
        cand(8'h81, 8'h00, 8'h00, 16'h0000, 8'h00, 64'h0, 1'b1);
        cand(8'h7f, 8'h7f, 8'hff, 16'hffff, 8'hff, 64'h2, 1'b0);
        cand(8'h80, 8'h05, 8'hff, 16'hffff, 8'hff, 64'h2, 1'b0);
        cand(8'h80, 8'h06, 8'h20, 16'hffff, 8'hff, 64'h2, 1'b0);
        cand(8'h80, 8'h06, 8'h21, 16'h4e5c, 8'hff, 64'h2, 1'b0);
        cand(8'h80, 8'h06, 8'h21, 16'h4e5e, 8'h00, 64'h0, 1'b1);
        cand(8'h80, 8'h06, 8'h21, 16'h4e5d, 8'h7f, 64'h2, 1'b0);
        cand(8'h80, 8'h06, 8'h21, 16'h4e5d, 8'h80, 64'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cfg.traceable = i[0];
            cfg.profile_en = i[1];
            ann_start = 1'b1;
            tick(1);
            ann_start = 1'b0;
            cfg.utc_offset = 16'h0011;
            tick(1);
            chk(ann_q, {{3{i[0]}}, 1'b1, i[0], 16'h0025, 8'h20,
                i[1] ? 8'h07 : (i[0] ? 8'h06 : 8'h0d)});
            cfg.utc_offset = 16'h0025;
        end
        cfg.traceable = 1'b0;
        src_u.second();
        tick(4);
        sec_step(ZA);
        chk(tb_sec_q, 32'h6a60b);
        chk(uart_fail_q, 1'b0);
        sec_step("$GPGGA,010203.00,4807.038,N*");
        chk(uart_fail_q, 1'b1);
        sec_step("$GPZDA,020304.00,06,01,1970,00,00*");
        chk(tb_sec_q, 32'h6a60b);
        chk(uart_fail_q, 1'b0);
        cfg.traceable = 1'b1;
        sec_step(ZA);
        chk(tb_sec_q, 32'h6a630);
        tick(TO_CYC + 20);
        chk({pps_lost_q, tb_state_q}, {1'b1, TB_FREE});
        results();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
endmodule
